// ---- core/direct_io_signal_mapper.sv ----
// Added by the designer: the placing of the registers and the AXI4-Lite interface to the registers.
module direct_io_signal_mapper import io_map_pkg::*; #(
  parameter int N_TERM = 6,
  parameter int TQ_W   = 16
) (
  input  wire logic                core_clk,      // Core clock, 10 MHz
  input  wire logic                rstn,          // Async reset, active low
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,  // Write address
  input  wire logic                s_axi_awvalid, // Write address valid
  output logic                     s_axi_awready, // Write address ready
  input  wire logic [31:0]         s_axi_wdata,   // Write data
  input  wire logic [3:0]          s_axi_wstrb,   // Write byte strobes
  input  wire logic                s_axi_wvalid,  // Write data valid
  output logic                     s_axi_wready,  // Write data ready
  output logic [1:0]               s_axi_bresp,   // Write response
  output logic                     s_axi_bvalid,  // Write response valid
  input  wire logic                s_axi_bready,  // Write response ready
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,  // Read address
  input  wire logic                s_axi_arvalid, // Read address valid
  output logic                     s_axi_arready, // Read address ready
  output logic [31:0]              s_axi_rdata,   // Read data
  output logic [1:0]               s_axi_rresp,   // Read response
  output logic                     s_axi_rvalid,  // Read data valid
  input  wire logic                s_axi_rready,  // Read data ready
  input  wire logic [N_TERM-1:0]   din_pins,      // Input terminals, 1 = current flows
  output logic [N_TERM-1:0]        dout_pins,     // Output terminals, 1 = current flows
  output logic [IN_FUNCS-1:0]      in_func,       // Input functions, by code
  input  wire logic                remote_interlock_assigned, // Interlock on remote I/O
  input  wire logic                remote_interlock_on,       // Remote interlock level
  input  wire logic [TQ_W-1:0]     torque_level,  // Present output torque
  input  wire logic [GEN_W-1:0]    gen_status,    // Driver status, codes 128..205
  input  wire logic [INFO_W-1:0]   info_event,    // Information events, codes 224..255
  output logic                     irq            // Interrupt, level, active high
);
  typedef struct packed {
    logic [N_TERM-1:0][CODE_W-1:0] in_sel;
    logic [N_TERM-1:0][CODE_W-1:0] out_sel;
    logic [N_TERM-1:0]             in_nc;
    logic [N_TERM-1:0]             out_nc;
    logic [TQ_W-1:0]               torque_limit;
    logic [IRQ_W-1:0]              irq_status;
    logic [IRQ_W-1:0]              irq_mask;
    logic [N_TERM-1:0]             din_prev;
    logic                          ovl_prev;
    logic                          info_prev;
    logic [IN_FUNCS-1:0]           in_func;
    logic [N_TERM-1:0]             dout;
    logic                          aw_have;
    logic [ADDR_W-1:0]             aw_addr;
    logic                          w_have;
    logic [31:0]                   wdata;
    logic [3:0]                    wstrb;
    logic                          bvalid;
    logic [1:0]                    bresp;
    logic                          rvalid;
    logic [31:0]                   rdata;
    logic [1:0]                    rresp;
  } state_t;

  state_t s_q;
  state_t s_d;

  logic                 ovl_now;
  logic [255:0]         out_funcs;
  logic [N_TERM-1:0]    out_hit;

  // Overload detect and the full output function map by code
  assign ovl_now   = torque_level >= s_q.torque_limit;
  assign out_funcs = {info_event, {GAP_W{1'b0}}, ovl_now, gen_status, {IN_FUNCS{1'b0}}};

  // One selector per output terminal
  genvar g;
  generate
    for (g = 0; g < N_TERM; g++) begin : g_out
      code_select #(.N_FUNCS(256)) u_sel (
        .code  (s_q.out_sel[g]),
        .funcs (out_funcs),
        .hit   (out_hit[g])
      );
    end
  endgenerate

  // Next state: mapping, events, bus
  always_comb begin
    logic [N_TERM-1:0]   din_log;
    logic [IN_FUNCS-1:0] in_f;
    logic                il_direct;
    logic [IRQ_W-1:0]    irq_set;
    logic [IRQ_W-1:0]    irq_clr;
    logic                wr_ok;
    logic                rd_ok;
    logic [31:0]         rd_data;
    din_log   = din_pins ^ s_q.in_nc;
    in_f      = '0;
    il_direct = 1'b0;
    irq_set   = '0;
    irq_clr   = '0;
    wr_ok     = 1'b0;
    rd_ok     = 1'b0;
    rd_data   = '0;
    s_d       = s_q;

    // Route each input terminal onto its function, repeated ones OR together
    for (int i = 0; i < N_TERM; i++) begin
      if (s_q.in_sel[i] != CODE_NONE && s_q.in_sel[i] < CODE_W'(IN_FUNCS)) begin
        in_f[s_q.in_sel[i][IN_IDX_W-1:0]] = in_f[s_q.in_sel[i][IN_IDX_W-1:0]] | din_log[i];
      end
      if (s_q.in_sel[i] == INTERLOCK_CODE) begin
        il_direct = 1'b1;
      end
    end

    // Interlock: forced on when unassigned, AND when on both sides
    if (!il_direct && !remote_interlock_assigned) begin
      in_f[INTERLOCK_CODE[IN_IDX_W-1:0]] = 1'b1;
    end else if (!il_direct) begin
      in_f[INTERLOCK_CODE[IN_IDX_W-1:0]] = remote_interlock_on;
    end else if (remote_interlock_assigned) begin
      in_f[INTERLOCK_CODE[IN_IDX_W-1:0]] = in_f[INTERLOCK_CODE[IN_IDX_W-1:0]] &
                                           remote_interlock_on;
    end
    s_d.in_func = in_f;

    // Output terminals carry the inverted state when normally closed
    s_d.dout = out_hit ^ s_q.out_nc;

    // Events: input changes, overload rise, rise of the OR of all information events
    irq_set[N_TERM-1:0]  = din_log ^ s_q.din_prev;
    irq_set[IRQ_OVL_BIT] = ovl_now & ~s_q.ovl_prev;
    irq_set[IRQ_INFO_BIT] = (|info_event) & ~s_q.info_prev;
    s_d.din_prev  = din_log;
    s_d.ovl_prev  = ovl_now;
    s_d.info_prev = |info_event;

    // Capture write address and data in either order
    if (s_axi_awvalid && !s_q.aw_have) begin
      s_d.aw_have = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_q.w_have) begin
      s_d.w_have = 1'b1;
      s_d.wdata  = s_axi_wdata;
      s_d.wstrb  = s_axi_wstrb;
    end

    // Perform the write once both halves are held
    if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
      for (int i = 0; i < N_TERM; i++) begin
        if (s_q.aw_addr == ADDR_IN_SEL + ADDR_W'(i) * ADDR_STEP) begin
          wr_ok = 1'b1;
          if (s_q.wstrb[0]) begin
            s_d.in_sel[i] = s_q.wdata[CODE_W-1:0];
          end
        end
        if (s_q.aw_addr == ADDR_OUT_SEL + ADDR_W'(i) * ADDR_STEP) begin
          wr_ok = 1'b1;
          if (s_q.wstrb[0]) begin
            s_d.out_sel[i] = s_q.wdata[CODE_W-1:0];
          end
        end
      end
      case (s_q.aw_addr)
        ADDR_POLARITY: begin
          wr_ok = 1'b1;
          if (s_q.wstrb[0]) begin
            s_d.in_nc = s_q.wdata[N_TERM-1:0];
          end
          if (s_q.wstrb[1]) begin
            s_d.out_nc = s_q.wdata[POL_OUT_LSB +: N_TERM];
          end
        end
        ADDR_TORQUE_LIM: begin
          wr_ok = 1'b1;
          if (s_q.wstrb[0]) begin
            s_d.torque_limit[7:0] = s_q.wdata[7:0];
          end
          if (s_q.wstrb[1]) begin
            s_d.torque_limit[TQ_W-1:8] = s_q.wdata[TQ_W-1:8];
          end
        end
        ADDR_TERM_STATUS: wr_ok = 1'b1;  // Read only, write ignored
        ADDR_IRQ_STATUS: begin
          wr_ok = 1'b1;
          if (s_q.wstrb[0]) begin
            irq_clr = s_q.wdata[IRQ_W-1:0];
          end
        end
        ADDR_IRQ_MASK: begin
          wr_ok = 1'b1;
          if (s_q.wstrb[0]) begin
            s_d.irq_mask = s_q.wdata[IRQ_W-1:0];
          end
        end
        default: ;
      endcase
      s_d.aw_have = 1'b0;
      s_d.w_have  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end

    // Sticky status: a new event wins over a clear in the same cycle
    s_d.irq_status = (s_q.irq_status & ~irq_clr) | irq_set;

    // Read decode
    for (int i = 0; i < N_TERM; i++) begin
      if (s_axi_araddr == ADDR_IN_SEL + ADDR_W'(i) * ADDR_STEP) begin
        rd_ok   = 1'b1;
        rd_data = {24'h000000, s_q.in_sel[i]};
      end
      if (s_axi_araddr == ADDR_OUT_SEL + ADDR_W'(i) * ADDR_STEP) begin
        rd_ok   = 1'b1;
        rd_data = {24'h000000, s_q.out_sel[i]};
      end
    end
    case (s_axi_araddr)
      ADDR_POLARITY: begin
        rd_ok = 1'b1;
        rd_data[N_TERM-1:0]             = s_q.in_nc;
        rd_data[POL_OUT_LSB +: N_TERM]  = s_q.out_nc;
      end
      ADDR_TORQUE_LIM: begin
        rd_ok = 1'b1;
        rd_data[TQ_W-1:0] = s_q.torque_limit;
      end
      ADDR_TERM_STATUS: begin
        rd_ok = 1'b1;
        rd_data[N_TERM-1:0]            = s_q.din_prev;
        rd_data[ST_OUT_LSB +: N_TERM]  = s_q.dout ^ s_q.out_nc;
        rd_data[ST_INTLK_BIT]          = s_q.in_func[INTERLOCK_CODE[IN_IDX_W-1:0]];
      end
      ADDR_IRQ_STATUS: begin
        rd_ok = 1'b1;
        rd_data[IRQ_W-1:0] = s_q.irq_status;
      end
      ADDR_IRQ_MASK: begin
        rd_ok = 1'b1;
        rd_data[IRQ_W-1:0] = s_q.irq_mask;
      end
      default: ;
    endcase

    // Read channel: one outstanding read
    if (s_axi_arvalid && !s_q.rvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rdata  = rd_ok ? rd_data : 32'h00000000;
      s_d.rresp  = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
  end

  // State register with reset defaults
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_q              <= '0;
      s_q.in_sel       <= IN_SEL_RST;
      s_q.out_sel      <= OUT_SEL_RST;
      s_q.in_nc        <= IN_NC_RST;
      s_q.out_nc       <= OUT_NC_RST;
      s_q.torque_limit <= TQ_LIM_RST;
      s_q.irq_mask     <= MASK_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Port drive
  assign s_axi_awready = !s_q.aw_have;
  assign s_axi_wready  = !s_q.w_have;
  assign s_axi_bvalid  = s_q.bvalid;
  assign s_axi_bresp   = s_q.bresp;
  assign s_axi_arready = !s_q.rvalid;
  assign s_axi_rvalid  = s_q.rvalid;
  assign s_axi_rdata   = s_q.rdata;
  assign s_axi_rresp   = s_q.rresp;
  assign dout_pins     = s_q.dout;
  assign in_func       = s_q.in_func;
  assign irq           = |(s_q.irq_status & s_q.irq_mask);

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sequence info_armed;
    s_q.out_sel[0] >= CODE_INFO_LO && !s_q.out_nc[0] && info_event[s_q.out_sel[0][INFO_IDX_W-1:0]];
  endsequence

  a_ovl_drive: assert property (
    s_q.out_sel[0] == CODE_OVL && !s_q.out_nc[0] && torque_level >= s_q.torque_limit
    |=> dout_pins[0]) else $error("overload code did not drive terminal 0");

  a_info_drive: assert property (info_armed |=> dout_pins[0])
    else $error("information code did not drive terminal 0");

  a_in_reset: assert property ($rose(rstn) |-> s_q.in_sel == IN_SEL_RST)
    else $error("input assignments wrong after reset");

  a_out_reset: assert property ($rose(rstn) |-> s_q.out_sel == OUT_SEL_RST)
    else $error("output assignments wrong after reset");

  a_input_or: assert property (
    s_q.in_sel[0] == s_q.in_sel[1] && s_q.in_sel[0] != CODE_NONE &&
    s_q.in_sel[0] < CODE_W'(IN_FUNCS) && s_q.in_sel[0] != INTERLOCK_CODE &&
    ((din_pins[0] ^ s_q.in_nc[0]) || (din_pins[1] ^ s_q.in_nc[1]))
    |=> in_func[$past(s_q.in_sel[0][IN_IDX_W-1:0])]) else $error("repeated input not ORed");

  a_intlk_free: assert property (
    !remote_interlock_assigned && !(s_q.in_sel[0] == INTERLOCK_CODE ||
    s_q.in_sel[1] == INTERLOCK_CODE || s_q.in_sel[2] == INTERLOCK_CODE ||
    s_q.in_sel[3] == INTERLOCK_CODE || s_q.in_sel[4] == INTERLOCK_CODE ||
    s_q.in_sel[5] == INTERLOCK_CODE)
    |=> in_func[INTERLOCK_CODE[IN_IDX_W-1:0]]) else $error("unassigned interlock not ON");

  a_intlk_and: assert property (
    remote_interlock_assigned && !remote_interlock_on && s_q.in_sel[2] == INTERLOCK_CODE
    |=> !in_func[INTERLOCK_CODE[IN_IDX_W-1:0]]) else $error("interlock not ANDed");

  a_nc_invert: assert property (
    s_q.out_sel[2] == CODE_NONE [*2] |-> dout_pins[2] == $past(s_q.out_nc[2]))
    else $error("idle terminal 2 level not set by polarity");

  a_unsupported: assert property (
    s_q.out_sel[0] >= CODE_GAP_LO && s_q.out_sel[0] <= CODE_GAP_HI && !s_q.out_nc[0]
    |=> !dout_pins[0]) else $error("unsupported code drove terminal 0");
endmodule

// ---- core/io_map_pkg.sv ----
// Notes on behaviour
// - An output terminal set to code 206 goes active once output torque reaches the overload level.
// - An output terminal set to a code from 224 to 255 goes active while that information event is up.
// - There are six direct input terminals, each with its own function assignment.
// - After reset the input assignments for terminals 0 to 5 are 30, 1, 12, 104, 28 and 29.
// - A function assigned to several input terminals is active when any of them is active.
// - The interlock function is held ON when no terminal carries it.
// - The interlock function assigned both directly and remotely is ON only when both are ON.
// - There are six direct output terminals, each with its own function assignment.
// - After reset the output assignments for terminals 0 to 5 are 144, 137, 0, 142, 134 and 130.
// - ON means current for normally-open terminals and no current for normally-closed ones.
package io_map_pkg;
  localparam int CODE_W    = 8;
  localparam int IN_FUNCS  = 128;       // Input function codes 0..127
  localparam int IN_IDX_W  = 7;
  localparam int GEN_W     = 78;        // General status codes 128..205
  localparam int GAP_W     = 17;        // Unsupported codes 207..223
  localparam int INFO_W    = 32;        // Information codes 224..255
  localparam int INFO_IDX_W = 5;

  localparam logic [CODE_W-1:0] CODE_NONE     = 8'h00;
  localparam logic [CODE_W-1:0] CODE_OVL      = 8'hCE;  // 206
  localparam logic [CODE_W-1:0] CODE_INFO_LO  = 8'hE0;  // 224
  localparam logic [CODE_W-1:0] CODE_GAP_LO   = 8'hCF;  // 207
  localparam logic [CODE_W-1:0] CODE_GAP_HI   = 8'hDF;  // 223
  localparam logic [CODE_W-1:0] INTERLOCK_CODE = 8'h02; // Interlock input function

  // Assignment defaults, terminal 0 in the low byte
  localparam logic [5:0][CODE_W-1:0] IN_SEL_RST  = {8'h1D, 8'h1C, 8'h68, 8'h0C, 8'h01, 8'h1E};
  localparam logic [5:0][CODE_W-1:0] OUT_SEL_RST = {8'h82, 8'h86, 8'h8E, 8'h00, 8'h89, 8'h90};

  // Register byte addresses
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_IN_SEL      = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_OUT_SEL     = 8'h20;
  localparam logic [ADDR_W-1:0] ADDR_POLARITY    = 8'h40;
  localparam logic [ADDR_W-1:0] ADDR_TORQUE_LIM  = 8'h44;
  localparam logic [ADDR_W-1:0] ADDR_TERM_STATUS = 8'h48;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS  = 8'h4C;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK    = 8'h50;
  localparam logic [ADDR_W-1:0] ADDR_STEP        = 8'h04;

  // Field positions
  localparam int POL_OUT_LSB   = 8;
  localparam int ST_OUT_LSB    = 8;
  localparam int ST_INTLK_BIT  = 16;
  localparam int IRQ_OVL_BIT   = 6;
  localparam int IRQ_INFO_BIT  = 7;
  localparam int IRQ_W         = 8;

  // Reset values
  localparam logic [5:0]  IN_NC_RST   = 6'h00;
  localparam logic [5:0]  OUT_NC_RST  = 6'h20;   // Alarm terminal is normally closed
  localparam logic [15:0] TQ_LIM_RST  = 16'hFFFF;
  localparam logic [IRQ_W-1:0] MASK_RST = 8'h00;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- core/code_select.sv ----
// Picks the function line named by one assignment code; code zero never hits
module code_select import io_map_pkg::*; #(
  parameter int N_FUNCS = 256
) (
  input  wire logic [CODE_W-1:0]  code,   // Assignment code
  input  wire logic [N_FUNCS-1:0] funcs,  // Function lines by code
  output logic                    hit     // Selected function active
);
  // Zero and any code whose line is tied low read inactive
  assign hit = (code != CODE_NONE) && funcs[code];
endmodule

// ---- testbench/io_ctrl_model.sv ----
// External controller on the I/O connector: energises the input terminals
module io_ctrl_model (
  input  wire logic       core_clk,  // Core clock
  input  wire logic [5:0] drive_req, // Terminals the controller wants energised
  input  wire logic       slow,      // Add one cycle of output-stage lag
  output logic      [5:0] din_pins   // Current into the input terminals
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] stage = 6'h00;

  // Output stage of the controller, promptly or one cycle late
  initial din_pins = 6'h00;
  always @(posedge core_clk) begin
    stage <= drive_req;
    din_pins <= slow ? stage : drive_req;
  end
endmodule

// ---- testbench/tb_top.sv ----
module tb_top import io_map_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [7:0] code;
    logic       gen;
    logic       info;
    logic       tq;
    logic       want;
  } row_t;
  logic               core_clk = 1'b0;
  logic               rstn = 1'b0;
  logic [ADDR_W-1:0]  awaddr = '0, araddr = '0;
  logic               awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic               arvalid = 1'b0, rready = 1'b0;
  logic [31:0]        wdata = '0, rdata;
  logic               awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]         bresp, rresp, r;
  logic [5:0]         drive_req = 6'h00, din_pins, dout_pins;
  logic [IN_FUNCS-1:0] in_func;
  logic               rem_asg = 1'b0, rem_on = 1'b0, slow = 1'b0;
  logic [15:0]        torque_level = 16'h0000;
  logic [GEN_W-1:0]   gen_status = '0;
  logic [INFO_W-1:0]  info_event = '0;
  logic [31:0]        d;
  int                 failures = 0, num_checks = 0;
  logic [7:0] in_rst[6]  = '{8'h1E, 8'h01, 8'h0C, 8'h68, 8'h1C, 8'h1D};
  logic [7:0] out_rst[6] = '{8'h90, 8'h89, 8'h00, 8'h8E, 8'h86, 8'h82};
  row_t rows[12] = '{'{8'h80, 1'b1, 1'b0, 1'b0, 1'b1}, '{8'h80, 1'b0, 1'b1, 1'b1, 1'b0},
                     '{8'hCD, 1'b1, 1'b0, 1'b0, 1'b1}, '{8'hCE, 1'b0, 1'b0, 1'b1, 1'b1},
                     '{8'hCE, 1'b1, 1'b1, 1'b0, 1'b0}, '{8'hE0, 1'b0, 1'b1, 1'b0, 1'b1},
                     '{8'hFF, 1'b0, 1'b1, 1'b0, 1'b1}, '{8'hFF, 1'b1, 1'b0, 1'b1, 1'b0},
                     '{8'h00, 1'b1, 1'b1, 1'b1, 1'b0}, '{8'h05, 1'b1, 1'b1, 1'b1, 1'b0},
                     '{8'hD2, 1'b1, 1'b1, 1'b1, 1'b0}, '{8'hDF, 1'b1, 1'b1, 1'b1, 1'b0}};

  direct_io_signal_mapper i_direct_io_signal_mapper (
    .core_clk(core_clk), .rstn(rstn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .din_pins(din_pins), .dout_pins(dout_pins), .in_func(in_func),
    .remote_interlock_assigned(rem_asg), .remote_interlock_on(rem_on),
    .torque_level(torque_level), .gen_status(gen_status), .info_event(info_event),
    .irq(irq)
  );
  io_ctrl_model i_io_ctrl_model (
    .core_clk(core_clk), .drive_req(drive_req), .slow(slow), .din_pins(din_pins)
  );

  // 10 MHz core clock
  always #50 core_clk = ~core_clk;

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] want);
    num_checks++;
    if (seen !== want) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, want, seen);
    end
  endtask

  // Write with address and data offered together, each released when taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic done;
    done = 1'b0;
    rs = 2'h3;
    @(posedge core_clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= v;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 50 && !done; n++) begin
      @(posedge core_clk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid) begin
        rs = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done)
      failures++;
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic done;
    done = 1'b0;
    rs = 2'h3;
    v = '0;
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 50 && !done; n++) begin
      @(posedge core_clk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid) begin
        v = rdata;
        rs = rresp;
        rready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done)
      failures++;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    axi_write(a, v, r);
    chk("bresp", r, RESP_OKAY);
  endtask

  task automatic settle;
    repeat (5) @(posedge core_clk);
  endtask

  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge core_clk);
    failures++;
    tally_and_finish;
  end

  // Main sequence
  initial begin
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    settle;
    chk("dout idle", dout_pins, 6'h20);
    chk("irq idle", irq, 1'b0);
    for (int i = 0; i < 6; i++) begin
      axi_read(ADDR_IN_SEL + 8'(4 * i), d, r);
      chk("in_sel", d, in_rst[i]);
      axi_read(ADDR_OUT_SEL + 8'(4 * i), d, r);
      chk("out_sel", d, out_rst[i]);
    end
    // Interlock with no assignment, then direct and remote sources
    chk("interlock free", in_func[2], 1'b1);
    wr(ADDR_IN_SEL + 8'h08, 32'h0000_0002);
    rem_asg <= 1'b1;
    drive_req <= 6'h04;
    settle;
    chk("interlock and 0", in_func[2], 1'b0);
    rem_on <= 1'b1;
    settle;
    chk("interlock and 1", in_func[2], 1'b1);
    drive_req <= 6'h00;
    slow <= 1'b1;
    settle;
    chk("interlock direct off", in_func[2], 1'b0);
    rem_asg <= 1'b0;
    wr(ADDR_IN_SEL + 8'h08, 32'h0000_000C);
    // Same function on terminals 0 and 1
    wr(ADDR_IN_SEL + 8'h04, 32'h0000_001E);
    drive_req <= 6'h02;
    settle;
    chk("or term1", in_func[30], 1'b1);
    drive_req <= 6'h01;
    settle;
    chk("or term0", in_func[30], 1'b1);
    drive_req <= 6'h00;
    settle;
    chk("or none", in_func[30], 1'b0);
    wr(ADDR_POLARITY, 32'h0000_2001);
    settle;
    chk("input nc", in_func[30], 1'b1);
    wr(ADDR_POLARITY, 32'h0000_2000);
    // Output code table on terminal 0
    slow <= 1'b0;
    wr(ADDR_TORQUE_LIM, 32'h0000_0100);
    foreach (rows[k]) begin
      wr(ADDR_OUT_SEL, {24'h0, rows[k].code});
      gen_status <= {GEN_W{rows[k].gen}};
      info_event <= {INFO_W{rows[k].info}};
      torque_level <= rows[k].tq ? 16'h0100 : 16'h00FF;
      settle;
      chk("direct_output_terminal_0", dout_pins[0], rows[k].want);
      chk("dout5", dout_pins[5], !rows[k].gen);
    end
    // Overload interrupt: masked, unmasked, cleared
    torque_level <= 16'h0000;
    wr(ADDR_IRQ_MASK, 32'h0000_0000);
    wr(ADDR_IRQ_STATUS, 32'h0000_00FF);
    torque_level <= 16'h0100;
    settle;
    chk("irq masked", irq, 1'b0);
    wr(ADDR_IRQ_MASK, 32'h0000_0040);
    settle;
    chk("irq raised", irq, 1'b1);
    axi_read(ADDR_IRQ_STATUS, d, r);
    chk("ovl status", d[IRQ_OVL_BIT], 1'b1);
    wr(ADDR_IRQ_STATUS, 32'h0000_0040);
    settle;
    chk("irq cleared", irq, 1'b0);
    // Unmapped address
    axi_read(8'h80, d, r);
    chk("unmapped rresp", r, RESP_SLVERR);
    chk("unmapped rdata", d, 32'h0000_0000);
    axi_write(8'h80, 32'hFFFF_FFFF, r);
    chk("unmapped bresp", r, RESP_SLVERR);
    // Reset in mid-run brings the default assignments back
    @(posedge core_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk("dout in reset", dout_pins, 6'h00);
    rstn <= 1'b1;
    settle;
    axi_read(ADDR_OUT_SEL, d, r);
    chk("out_sel0 after reset", d, 32'h0000_0090);
    axi_read(ADDR_IN_SEL + 8'h04, d, r);
    chk("in_sel1 after reset", d, 32'h0000_0001);
    chk("dout after reset", dout_pins, 6'h1B);
    tally_and_finish;
  end
endmodule
